// file: inc/arb_if.sv
`timescale 1ns/100ps
`default_nettype none
interface arb_if;
    logic [3:0] req;
    logic       bbsy;
    logic       gnt_vld;
    logic [1:0] gnt_lvl;
    logic       timeout;
    modport arbiter (input req, input bbsy, output gnt_vld,
                     output gnt_lvl, output timeout);
    modport ctrl (output req, output bbsy, input gnt_vld,
                  input gnt_lvl, input timeout);
endinterface
`default_nettype wire

// file: inc/vme_esc_cfg.svh
`ifndef VME_ESC_CFG_SVH
`define VME_ESC_CFG_SVH

`define CLK_NS      20
`define ARB_TO_NS   8000
`define ARB_TO_CYC  ((`ARB_TO_NS + `CLK_NS - 1) / `CLK_NS)
`define BUS_TO_NS   64000
`define BUS_TO_CYC  ((`BUS_TO_NS + `CLK_NS - 1) / `CLK_NS)

`define ADDR_SUM    8'h00
`define ADDR_MASK   8'h04
`define ADDR_CTRL   8'h08
`define ADDR_PCLR   8'h0C

`define XTO_BIT     23
`define ATO_BIT     22
`define GL_LSB      20
`define AM_LSB      14
`define DS1_BIT     13
`define DS0_BIT     12
`define SR_BIT      11
`define PEND_LSB    4
`define SENT_LSB    0
`define IEN_BIT     0

`define AM_RST      6'h3F
`define ROAK_RST    7'h7F
`define EV_MASK     32'h00C0_07F0
`define SYNC_RST    27'h7FF_FFFF

`endif

// file: inc/vme_esc_pkg.sv
`default_nettype none
package vme_esc_pkg;
    typedef enum logic [2:0] {
        ARB_IDLE    = 3'h1,
        ARB_GRANT   = 3'h2,
        ARB_RELEASE = 3'h4
    } arb_state_e;
    typedef enum logic [2:0] {
        BT_IDLE  = 3'h1,
        BT_COUNT = 3'h2,
        BT_BERR  = 3'h4
    } bus_timer_e;
endpackage
`default_nettype wire

// file: rtl/arb_core.sv
`timescale 1ns/100ps
`default_nettype none
`include "vme_esc_cfg.svh"
module arb_core
    import vme_esc_pkg::*;
#(
    parameter int unsigned TO_CYC = `ARB_TO_CYC
) (
    input  wire logic i_clk,
    input  wire logic i_rst,
    arb_if.arbiter    bus
);
    arb_state_e  st_q;
    logic [15:0] cnt_q;
    logic [1:0]  top_lvl;

    // The highest numbered request level wins the grant.
    always_comb begin
        top_lvl = 2'h0;
        for (int i = 0; i < 4; i++) begin
            if (bus.req[i]) top_lvl = 2'(i);
        end
    end

    // Grant sequencer; the timer runs only while a grant waits unused.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_q        <= ARB_IDLE;
            cnt_q       <= 16'h0000;
            bus.gnt_vld <= 1'b0;
            bus.gnt_lvl <= 2'h0;
            bus.timeout <= 1'b0;
        end else begin
            bus.timeout <= 1'b0;
            case (st_q)
                ARB_IDLE: begin
                    cnt_q <= 16'h0000;
                    if (|bus.req && !bus.bbsy) begin
                        st_q        <= ARB_GRANT;
                        bus.gnt_vld <= 1'b1;
                        bus.gnt_lvl <= top_lvl;
                    end
                end
                ARB_GRANT: begin
                    cnt_q <= cnt_q + 16'h0001;
                    if (bus.bbsy) begin
                        st_q        <= ARB_IDLE;
                        bus.gnt_vld <= 1'b0;
                    end else if (cnt_q == 16'(TO_CYC - 1)) begin
                        st_q        <= ARB_RELEASE;
                        bus.gnt_vld <= 1'b0;
                        bus.timeout <= 1'b1;
                    end
                end
                ARB_RELEASE: begin
                    st_q <= ARB_IDLE;
                end
                default: begin
                    st_q        <= ARB_IDLE;
                    bus.gnt_vld <= 1'b0;
                end
            endcase
        end
    end

    arb_release_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        bus.timeout |-> !bus.gnt_vld ##1 !bus.gnt_vld)
        else $error("Grant still driven after arbitration timeout.");
endmodule
`default_nettype wire

// file: rtl/vme_error_status_capture.sv
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "vme_esc_cfg.svh"
module vme_error_status_capture
    import vme_esc_pkg::*;
#(
    parameter int unsigned ARB_TO_CYC = `ARB_TO_CYC,
    parameter int unsigned BUS_TO_CYC = `BUS_TO_CYC
) (
    input  wire logic        I_REF_CLK,
    input  wire logic        I_SYS_RST,
    input  wire logic [7:0]  I_ADDR,
    input  wire logic [31:0] I_WDATA,
    input  wire logic        I_WR,
    input  wire logic        I_RD,
    output var  logic [31:0] O_RDATA,
    output var  logic        O_IRQ,
    input  wire logic [5:0]  I_AM,
    input  wire logic        I_DS1_N,
    input  wire logic        I_DS0_N,
    input  wire logic        I_SYSRESET_N,
    input  wire logic [7:1]  I_IRQ_N,
    input  wire logic        I_IACK_N,
    input  wire logic [2:0]  I_IACK_LVL,
    input  wire logic [3:0]  I_BR_N,
    input  wire logic        I_BBSY_N,
    input  wire logic        I_DTACK_N,
    input  wire logic        I_BERR_N,
    output var  logic        O_BERR_N_O,
    output var  logic        O_BERR_N_OE,
    output var  logic [3:0]  O_BG_N,
    input  wire logic [3:0]  I_HOST_BUS_REQUEST_LEVEL_IRQ,
    input  wire logic [3:0]  I_HOST_BUS_REQUEST_LEVEL_IDENT
);
    arb_if arb ();

    logic [26:0] sync1_q;
    logic [26:0] sync2_q;
    logic [5:0]  am_s;
    logic        ds1_n_s;
    logic        ds0_n_s;
    logic        sr_n_s;
    logic [7:1]  irq_n_s;
    logic        iack_n_s;
    logic [2:0]  iack_lvl_s;
    logic [3:0]  br_n_s;
    logic        bbsy_n_s;
    logic        dtack_n_s;
    logic        berr_n_s;

    logic        ato_q;
    logic        ato_d;
    logic        xto_q;
    logic        xto_d;
    logic        xto_ev_q;
    logic        frz_nx;
    logic        sr_q;
    logic        sr_d;
    logic [1:0]  gl_q;
    logic [5:0]  am_q;
    logic        ds1_q;
    logic        ds0_q;
    logic [6:0]  pend_q;
    logic [6:0]  pend_d;
    logic [6:0]  irq_act;
    logic [6:0]  roak_clr;
    logic [6:0]  rora_clr;
    logic [3:0]  sent_q;
    logic [3:0]  sent_d;
    logic [31:0] mask_q;
    logic        ien_q;
    logic [6:0]  roak_q;
    logic [31:0] sum;
    logic [31:0] rd_mux;
    logic        wr_sum;
    logic        wr_pclr;
    bus_timer_e  bt_q;
    logic [15:0] bt_cnt_q;
    logic        ds_act;

    // Every bus pin crosses into the clock domain through two flops.
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            sync1_q <= `SYNC_RST;
            sync2_q <= `SYNC_RST;
        end else begin
            sync1_q <= {I_AM, I_DS1_N, I_DS0_N, I_SYSRESET_N, I_IRQ_N,
                        I_IACK_N, I_IACK_LVL, I_BR_N, I_BBSY_N,
                        I_DTACK_N, I_BERR_N};
            sync2_q <= sync1_q;
        end
    end

    // Unpack the synchronised pins in the order they were packed.
    assign {am_s, ds1_n_s, ds0_n_s, sr_n_s, irq_n_s, iack_n_s,
            iack_lvl_s, br_n_s, bbsy_n_s, dtack_n_s, berr_n_s} = sync2_q;

    // Arbiter sees active-high requests and bus busy.
    assign arb.req  = ~br_n_s;
    assign arb.bbsy = ~bbsy_n_s;

    arb_core #(
        .TO_CYC (ARB_TO_CYC)
    ) u_arb (
        .i_clk (I_REF_CLK),
        .i_rst (I_SYS_RST),
        .bus   (arb.arbiter)
    );

    // Grant lines are low-active, one line for the granted level.
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            O_BG_N <= 4'hF;
        end else if (arb.gnt_vld) begin
            O_BG_N <= ~(4'h1 << arb.gnt_lvl);
        end else begin
            O_BG_N <= 4'hF;
        end
    end

    assign wr_sum  = I_WR && (I_ADDR == `ADDR_SUM);
    assign wr_pclr = I_WR && (I_ADDR == `ADDR_PCLR);
    assign ds_act  = !ds0_n_s || !ds1_n_s;

    // Sticky flags: a set in the clearing cycle wins over the clear.
    // Arbitration timeout flag.
    assign ato_d = arb.timeout
                 | (ato_q & ~(wr_sum & I_WDATA[`ATO_BIT]));
    assign xto_d = xto_ev_q
                 | (xto_q & ~(wr_sum & I_WDATA[`XTO_BIT]));
    assign sr_d  = !sr_n_s
                 | (sr_q & ~(wr_sum & I_WDATA[`SR_BIT]));
    assign frz_nx = ato_d | xto_d;

    // Flag registers; only a written one clears, a zero keeps the flag.
    // Zero leaves flags.
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            ato_q <= 1'b0;
            xto_q <= 1'b0;
            sr_q  <= 1'b0;
        end else begin
            ato_q <= ato_d;
            xto_q <= xto_d;
            sr_q  <= sr_d;
        end
    end

    // Snapshots follow the bus until a timeout, then freeze so software
    // sees the state at the moment of failure.
    // Grant level snapshot.
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            gl_q <= 2'h0;
        end else if (arb.gnt_vld && !frz_nx) begin
            gl_q <= arb.gnt_lvl;
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            am_q  <= `AM_RST;
            ds1_q <= 1'b0;
            ds0_q <= 1'b0;
        end else if (!frz_nx) begin
            am_q  <= am_s;
            ds1_q <= !ds1_n_s;
            ds0_q <= !ds0_n_s;
        end
    end

    // Pending and acknowledge logic, one slice per request level.
    for (genvar k = 0; k < 7; k++) begin : g_pend
        assign irq_act[k]  = !irq_n_s[k+1];
        assign roak_clr[k] = roak_q[k] && !iack_n_s
                           && (iack_lvl_s == 3'(k + 1));
        assign rora_clr[k] = !roak_q[k] && wr_pclr
                           && I_WDATA[`PEND_LSB + k];
        assign pend_d[k]   = irq_act[k]
                           | (pend_q[k] & ~(roak_clr[k] | rora_clr[k]));
    end

    // Sent-interrupt slices; an identify for a level clears it.
    for (genvar j = 0; j < 4; j++) begin : g_sent
        assign sent_d[j] = I_HOST_BUS_REQUEST_LEVEL_IRQ[j]
                         | (sent_q[j] & ~I_HOST_BUS_REQUEST_LEVEL_IDENT[j]);
    end

    // Sent fields ignore register writes; pending bits take writes only at the PCLR address.
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            pend_q <= 7'h00;
            sent_q <= 4'h0;
        end else begin
            pend_q <= pend_d;
            sent_q <= sent_d;
        end
    end

    // Bus timer: a strobed cycle nobody answers is ended with bus error.
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            bt_q        <= BT_IDLE;
            bt_cnt_q    <= 16'h0000;
            xto_ev_q    <= 1'b0;
            O_BERR_N_OE <= 1'b0;
        end else begin
            xto_ev_q <= 1'b0;
            case (bt_q)
                BT_IDLE: begin
                    bt_cnt_q <= 16'h0000;
                    if (ds_act && dtack_n_s && berr_n_s) begin
                        bt_q <= BT_COUNT;
                    end
                end
                BT_COUNT: begin
                    bt_cnt_q <= bt_cnt_q + 16'h0001;
                    if (!ds_act || !dtack_n_s || !berr_n_s) begin
                        bt_q <= BT_IDLE;
                    end else if (bt_cnt_q == 16'(BUS_TO_CYC - 1)) begin
                        bt_q        <= BT_BERR;
                        xto_ev_q    <= 1'b1;
                        O_BERR_N_OE <= 1'b1;
                    end
                end
                BT_BERR: begin
                    // Hold bus error until the master drops its strobes.
                    if (!ds_act) begin
                        bt_q        <= BT_IDLE;
                        O_BERR_N_OE <= 1'b0;
                    end
                end
                default: begin
                    bt_q        <= BT_IDLE;
                    O_BERR_N_OE <= 1'b0;
                end
            endcase
        end
    end

    // Open-drain pin: only ever pulled low.
    assign O_BERR_N_O = 1'b0;

    // Software control: mask, global enable and interrupter type.
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            mask_q <= 32'h0000_0000;
            ien_q  <= 1'b0;
            roak_q <= `ROAK_RST;
        end else if (I_WR && I_ADDR == `ADDR_MASK) begin
            mask_q <= I_WDATA & `EV_MASK;
        end else if (I_WR && I_ADDR == `ADDR_CTRL) begin
            ien_q  <= I_WDATA[`IEN_BIT];
            roak_q <= I_WDATA[`PEND_LSB +: 7];
        end
    end

    // Assemble the summary word from its fields.
    always_comb begin
        sum                      = 32'h0000_0000;
        sum[`XTO_BIT]            = xto_q;
        sum[`ATO_BIT]            = ato_q;
        sum[`GL_LSB +: 2]        = gl_q;
        sum[`AM_LSB +: 6]        = am_q;
        sum[`DS1_BIT]            = ds1_q;
        sum[`DS0_BIT]            = ds0_q;
        sum[`SR_BIT]             = sr_q;
        sum[`PEND_LSB +: 7]      = pend_q;
        sum[`SENT_LSB +: 4]      = sent_q;
    end

    // Read mux; unmapped and write-only addresses read as zero.
    always_comb begin
        case (I_ADDR)
            `ADDR_SUM:  rd_mux = sum;
            `ADDR_MASK: rd_mux = mask_q;
            `ADDR_CTRL: rd_mux = {21'h00_0000, roak_q, 3'h0, ien_q};
            default:    rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data stand for exactly the cycle after the strobe.
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            O_RDATA <= 32'h0000_0000;
        end else if (I_RD) begin
            O_RDATA <= rd_mux;
        end else begin
            O_RDATA <= 32'h0000_0000;
        end
    end

    // Interrupt line; system reset bypasses both mask and enable so a
    // driver can never miss a crate reset.
    // Gated timeout and pending interrupts.
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            O_IRQ <= 1'b0;
        end else begin
            O_IRQ <= sr_q | (ien_q & |(sum & mask_q));
        end
    end

    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (I_SYS_RST);

    ato_set_a: assert property (
        arb.timeout |=> ato_q)
        else $error("Arbitration timeout flag not set.");

    gl_frozen_a: assert property (
        frz_nx |=> $stable(gl_q))
        else $error("Grant level changed while frozen.");

    am_sample_a: assert property (
        !frz_nx |=> am_q == $past(am_s))
        else $error("Address modifier snapshot missed a sample.");

    ds1_capture_a: assert property (
        !frz_nx |=> ds1_q == !$past(ds1_n_s))
        else $error("Upper strobe snapshot wrong.");

    ds0_capture_a: assert property (
        !frz_nx |=> ds0_q == !$past(ds0_n_s))
        else $error("Lower strobe snapshot wrong.");

    sr_flag_a: assert property (
        !sr_n_s |=> sr_q)
        else $error("System reset flag not set.");

    sr_irq_a: assert property (
        sr_q |=> O_IRQ)
        else $error("System reset interrupt suppressed.");

    pend_set_a: assert property (
        irq_act[6] |=> pend_q[6])
        else $error("Pending bit for level seven not set.");

    roak_clear_a: assert property (
        roak_clr[6] && !irq_act[6] |=> !pend_q[6])
        else $error("Acknowledged level stayed pending.");

    sent_set_a: assert property (
        I_HOST_BUS_REQUEST_LEVEL_IRQ[3] |=> sent_q[3])
        else $error("Sent bit not set on host interrupt.");

    sent_clear_a: assert property (
        I_HOST_BUS_REQUEST_LEVEL_IDENT[3]
        && !I_HOST_BUS_REQUEST_LEVEL_IRQ[3] |=> !sent_q[3])
        else $error("Sent bit not cleared by identify.");

    xto_berr_a: assert property (
        xto_ev_q |-> O_BERR_N_OE ##1 xto_q)
        else $error("Transaction timeout without bus error and flag.");

    w0_keep_a: assert property (
        ato_q && wr_sum && !I_WDATA[`ATO_BIT] |=> ato_q)
        else $error("Writing zero cleared the arbitration flag.");
endmodule
`default_nettype wire

// file: tb/vme_error_status_capture_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "vme_esc_cfg.svh"
module vme_error_status_capture_tb;
    logic        clk      = 1'b0;
    logic        rst      = 1'b1;
    logic [7:0]  addr     = 8'h00;
    logic [31:0] wdata    = 32'h0000_0000;
    logic        wr       = 1'b0;
    logic        rd       = 1'b0;
    logic [5:0]  am       = 6'h3F;
    logic        ds1_n    = 1'b1;
    logic        ds0_n    = 1'b1;
    logic        sr_n     = 1'b1;
    logic [7:1]  irq_n    = 7'h7F;
    logic        iack_n   = 1'b1;
    logic [2:0]  iack_lvl = 3'h0;
    logic [3:0]  h_irq    = 4'h0;
    logic [3:0]  h_id     = 4'h0;
    logic [3:0]  req      = 4'h0;
    logic        slow     = 1'b0;
    logic [31:0] rdata;
    logic        irq;
    logic [3:0]  br_n;
    logic [3:0]  bg_n;
    logic        bbsy_n;
    logic        dtack_n;
    logic        berr_n;
    logic        berr_o;
    logic        berr_oe;
    int          n_tests     = 0;
    int          miscompares = 0;

    // Free-running reference clock.
    always #10 clk = ~clk;

    // Short timeouts keep the run brief; expectations follow them.
    vme_error_status_capture #(.ARB_TO_CYC(8), .BUS_TO_CYC(16)) dut_u (
        .I_REF_CLK(clk), .I_SYS_RST(rst), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_IRQ(irq), .I_AM(am),
        .I_DS1_N(ds1_n), .I_DS0_N(ds0_n), .I_SYSRESET_N(sr_n),
        .I_IRQ_N(irq_n), .I_IACK_N(iack_n), .I_IACK_LVL(iack_lvl),
        .I_BR_N(br_n), .I_BBSY_N(bbsy_n), .I_DTACK_N(dtack_n),
        .I_BERR_N(berr_n), .O_BERR_N_O(berr_o), .O_BERR_N_OE(berr_oe),
        .O_BG_N(bg_n), .I_HOST_BUS_REQUEST_LEVEL_IRQ(h_irq),
        .I_HOST_BUS_REQUEST_LEVEL_IDENT(h_id));

    vme_far_model far_u (
        .i_clk(clk), .i_rst(rst), .i_req(req), .i_slow(slow),
        .i_bg_n(bg_n), .i_ds_n(ds1_n & ds0_n), .i_berr_o(berr_o),
        .i_berr_oe(berr_oe), .o_br_n(br_n), .o_bbsy_n(bbsy_n),
        .o_dtack_n(dtack_n), .o_berr_n(berr_n));

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe, so sample there.
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] exp);
        logic [31:0] v;
        rd_reg(a, v);
        check(v & m, exp);
    endtask

    // Bounded wait for a summary flag; running out ends the run.
    task automatic poll(input logic [31:0] m);
        logic [31:0] v;
        for (int i = 0; i < 80; i++) begin
            rd_reg(`ADDR_SUM, v);
            if ((v & m) !== 32'h0000_0000) return;
        end
        miscompares++;
        test_done();
    endtask

    // Main sequence: each block exercises one group of summary fields.
    initial begin
        cyc(16);
        rst <= 1'b0;
        rd_chk(`ADDR_SUM, 32'hFFFF_FFFF, 32'h000F_C000);
        rd_chk(`ADDR_CTRL, 32'hFFFF_FFFF, 32'h0000_07F0);
        rd_chk(8'h10, 32'hFFFF_FFFF, 32'h0000_0000);
        cyc(1);
        am    <= 6'h15;
        ds1_n <= 1'b0;
        cyc(8);
        rd_chk(`ADDR_SUM, 32'hFFFF_FFFF, 32'h0005_6000);
        wr_reg(`ADDR_SUM, 32'hFFFF_FFFF);
        rd_chk(`ADDR_SUM, 32'hFFFF_FFFF, 32'h0005_6000);
        cyc(1);
        ds1_n <= 1'b1;
        sr_n  <= 1'b0;
        cyc(2);
        sr_n <= 1'b1;
        cyc(4);
        rd_chk(`ADDR_SUM, 32'h0000_3800, 32'h0000_0800);
        check({31'h0, irq}, 32'h0000_0001);
        wr_reg(`ADDR_SUM, 32'h0000_0000);
        rd_chk(`ADDR_SUM, 32'h0000_0800, 32'h0000_0800);
        wr_reg(`ADDR_SUM, 32'h0000_0800);
        rd_chk(`ADDR_SUM, 32'h0000_0800, 32'h0000_0000);
        check({31'h0, irq}, 32'h0000_0000);
        wr_reg(`ADDR_CTRL, 32'h0000_0401);
        wr_reg(`ADDR_MASK, 32'h0000_07F0);
        cyc(1);
        irq_n <= 7'b0111101;
        cyc(6);
        irq_n <= 7'h7F;
        cyc(4);
        rd_chk(`ADDR_SUM, 32'h0000_07F0, 32'h0000_0420);
        check({31'h0, irq}, 32'h0000_0001);
        cyc(1);
        iack_n   <= 1'b0;
        iack_lvl <= 3'h7;
        cyc(6);
        iack_lvl <= 3'h2;
        cyc(6);
        iack_n <= 1'b1;
        rd_chk(`ADDR_SUM, 32'h0000_07F0, 32'h0000_0020);
        wr_reg(`ADDR_PCLR, 32'h0000_0020);
        rd_chk(`ADDR_SUM, 32'h0000_07F0, 32'h0000_0000);
        check({31'h0, irq}, 32'h0000_0000);
        cyc(1);
        h_irq <= 4'b1001;
        cyc(1);
        h_irq <= 4'h0;
        rd_chk(`ADDR_SUM, 32'h0000_000F, 32'h0000_0009);
        wr_reg(`ADDR_SUM, 32'h0000_000F);
        rd_chk(`ADDR_SUM, 32'h0000_000F, 32'h0000_0009);
        cyc(1);
        h_id <= 4'b1000;
        cyc(1);
        h_id <= 4'h0;
        rd_chk(`ADDR_SUM, 32'h0000_000F, 32'h0000_0001);
        // A master that never takes its grant forces an arbitration timeout.
        wr_reg(`ADDR_MASK, 32'h00C0_0000);
        cyc(1);
        req  <= 4'b0100;
        slow <= 1'b1;
        poll(32'h0040_0000);
        cyc(1);
        req <= 4'h0;
        cyc(1);
        am <= 6'h2A;
        cyc(20);
        @(negedge clk);
        check({28'h0, bg_n}, 32'h0000_000F);
        rd_chk(`ADDR_SUM, 32'h007F_F000, 32'h0065_4000);
        check({31'h0, irq}, 32'h0000_0001);
        // A zero written over a set flag must leave it standing.
        wr_reg(`ADDR_SUM, 32'h0000_0000);
        rd_chk(`ADDR_SUM, 32'h0040_0000, 32'h0040_0000);
        wr_reg(`ADDR_SUM, 32'h0040_0000);
        cyc(4);
        rd_chk(`ADDR_SUM, 32'h007F_F000, 32'h002A_8000);
        check({31'h0, irq}, 32'h0000_0000);
        cyc(1);
        slow <= 1'b0;
        req  <= 4'b0010;
        for (int i = 0; i < 40 && bg_n[1] !== 1'b0; i++) begin
            @(negedge clk);
        end
        // A grant that never shows is a hang, so end the run here.
        if (bg_n[1] !== 1'b0) begin
            miscompares++;
            test_done();
        end
        check({28'h0, bg_n}, 32'h0000_000D);
        cyc(1);
        req <= 4'h0;
        cyc(20);
        rd_chk(`ADDR_SUM, 32'h00F0_0000, 32'h0010_0000);
        // A strobe with no acknowledge times out and pulls bus error.
        cyc(1);
        slow  <= 1'b1;
        ds0_n <= 1'b0;
        poll(32'h0080_0000);
        @(negedge clk);
        check({31'h0, berr_oe}, 32'h0000_0001);
        check({31'h0, berr_n}, 32'h0000_0000);
        cyc(1);
        ds0_n <= 1'b1;
        cyc(8);
        @(negedge clk);
        check({31'h0, berr_oe}, 32'h0000_0000);
        check({31'h0, berr_n}, 32'h0000_0001);
        rd_chk(`ADDR_SUM, 32'h00C0_3000, 32'h0080_1000);
        check({31'h0, irq}, 32'h0000_0001);
        wr_reg(`ADDR_SUM, 32'h0080_0000);
        rd_chk(`ADDR_SUM, 32'h00C0_0000, 32'h0000_0000);
        test_done();
    end
endmodule
`default_nettype wire

// file: tb/vme_far_model.sv
`timescale 1ns/100ps
`default_nettype none
module vme_far_model (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic [3:0] i_req,
    input  wire logic       i_slow,
    input  wire logic [3:0] i_bg_n,
    input  wire logic       i_ds_n,
    input  wire logic       i_berr_o,
    input  wire logic       i_berr_oe,
    output var  logic [3:0] o_br_n,
    output var  logic       o_bbsy_n,
    output var  logic       o_dtack_n,
    output var  logic       o_berr_n
);
    logic [3:0] bg_prev_q;
    logic [2:0] hold_q;

    // Requests stay low only while the bench asks for the bus.
    assign o_br_n = ~i_req;

    // A slow master never takes its grant, so the arbiter must time out.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            bg_prev_q <= 4'hF;
            hold_q    <= 3'h0;
        end else begin
            bg_prev_q <= i_bg_n;
            if (hold_q != 3'h0) begin
                hold_q <= hold_q - 3'h1;
            end else if (!i_slow && bg_prev_q == 4'hF && i_bg_n != 4'hF) begin
                hold_q <= 3'h6;
            end
        end
    end
    assign o_bbsy_n = (hold_q == 3'h0);

    // A prompt slave answers a strobe one cycle later; a slow one is mute.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_dtack_n <= 1'b1;
        end else begin
            o_dtack_n <= i_ds_n | i_slow;
        end
    end

    // Bus error is open drain with a pull-up, so a released line reads high.
    assign o_berr_n = !(i_berr_oe && !i_berr_o);
endmodule
`default_nettype wire
